// ===== verilog/hbsc_pkg.sv
/*
 * Shared constants and the state type of the half-bridge serial control port.
 * Assumes a 50 MHz system clock well above the serial clock of the far side.
 */
package hbsc_pkg;

    // ********************************************************************
    // Word layout
    // ********************************************************************
    localparam int        CMD_W        = 16;
    localparam int        NSW          = 6;
    localparam int        CMD_CLR      = 0;
    localparam int        CMD_SW_LSB   = 1;
    localparam int        CMD_PWM_LSB  = 7;
    localparam int        CMD_OLD_N    = 13;
    localparam int        CMD_OCS      = 14;
    localparam int        CMD_RUN      = 15;
    localparam int        ST_TP        = 0;
    localparam int        ST_SW_LSB    = 1;
    localparam int        ST_OVL       = 13;
    localparam int        ST_INH       = 14;
    localparam int        ST_PSF       = 15;
    localparam logic [5:0]  ST_UNUSED  = 6'h00;
    localparam logic [15:0] CMD_RESET  = 16'hE000;

    // ********************************************************************
    // Frame counting
    // ********************************************************************
    localparam logic [4:0] CNT_ZERO    = 5'h00;
    localparam logic [4:0] CNT_ONE     = 5'h01;
    localparam logic [4:0] FRAME_BITS  = 5'h10;
    localparam logic [4:0] CNT_MAX     = 5'h11;

    // ********************************************************************
    // Synchroniser lanes
    // ********************************************************************
    localparam int         SY_CS       = 0;
    localparam int         SY_CLK      = 1;
    localparam int         SY_DIN      = 2;
    localparam int         SY_PWM      = 3;
    localparam int         SY_TP       = 4;
    localparam int         SY_UV       = 5;
    localparam int         SY_SC       = 6;
    localparam int         SY_OT       = 12;
    localparam int         SY_OL       = 18;
    localparam int         SY_W        = 24;
    localparam logic [23:0] SY_RESET   = 24'h000001;

    // ********************************************************************
    // Port state
    // ********************************************************************
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] shin;
        logic [15:0] shout;
        logic [4:0]  cnt;
        logic        active;
        logic [5:0]  trip;
        logic        overload_flag;
        logic        supply_fail_flag;
        logic        dout;
        logic        doe;
        logic [5:0]  gate;
        logic        ol_en;
        logic        oc_en;
        logic        standby;
    } hbsc_state_t;

endpackage : hbsc_pkg

// ===== verilog/hbsc_sync_if.sv
/*
 * Carries synchronised input levels and their edge pulses.
 * Assumes all lanes are sampled on one system clock.
 */
`timescale 1ns/1ps
interface hbsc_sync_if #(parameter int W = hbsc_pkg::SY_W);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : hbsc_sync_if

// ===== verilog/hbsc_sync.sv
/*
 * Two-stage synchroniser bank with edge detection on the settled stage.
 * Assumes inputs are asynchronous to clk and change slower than clk.
 */
`timescale 1ns/1ps
module hbsc_sync (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Raw pins
    input  wire logic [hbsc_pkg::SY_W-1:0] async_in,
    // Synchronised result
    hbsc_sync_if.src                       sy
);

    typedef struct packed {
        logic [hbsc_pkg::SY_W-1:0] meta;
        logic [hbsc_pkg::SY_W-1:0] stable;
        logic [hbsc_pkg::SY_W-1:0] prev;
    } hbsc_sync_state_t;

    hbsc_sync_state_t q;
    hbsc_sync_state_t d;

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        d        = q;
        d.meta   = async_in;
        d.stable = q.meta;
        d.prev   = q.stable;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.meta   <= hbsc_pkg::SY_RESET;
            q.stable <= hbsc_pkg::SY_RESET;
            q.prev   <= hbsc_pkg::SY_RESET;
        end else begin
            q <= d;
        end
    end

    // ********************************************************************
    // Edges per lane
    // ********************************************************************
    for (genvar i = 0; i < hbsc_pkg::SY_W; i++) begin : g_lane
        assign sy.level[i] = q.stable[i];
        assign sy.rise[i]  = q.stable[i] & ~q.prev[i];
        assign sy.fall[i]  = ~q.stable[i] & q.prev[i];
    end

endmodule : hbsc_sync

// ===== verilog/hbsc_port.sv
/*
 * Serial control and status port of a triple half-bridge driver.
 * Takes a 16-bit command frame, returns a 16-bit status frame and
 * drives the six switch gates. Assumes every pin is asynchronous to
 * clk and that the serial clock stays well below a quarter of clk.
 */
`timescale 1ns/1ps

// Summary of operation
// - Frame starts on chip select falling
// - Data in sampled on serial clock fall
// - Command shifted in LSB first
// - Command applied only at chip select rise
// - Data out tri-stated while deselected
// - Data out changes on serial clock rise
// - Status shifted out LSB first
// - Clear bit resets supply-fail and overload
// - Bits 1-6 switch low/high sides on
// - Bits 7-12 gate switches with PWM
// - Bit 13 low enables open-load detection
// - Bit 14 high enables overcurrent shutdown
// - Bit 15 low is standby; serial works
// - Status bit 0 shows thermal prewarning
// - Status 1-6 show switch or open load
// - Status 13 set on fault switch-off
// - Status 14 is inverted run bit
// - Status 15 set on supply undervoltage
// - Reset loads command 0xE000
// - Frame carries sixteen command bits
// - Early abort leaves registers untouched
module hbsc_port (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Serial link pins
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       serial_in,
    output logic            serial_out,
    output logic            serial_out_oe,
    // PWM pin
    input  wire logic       pwm_in,
    // Analog detector levels
    input  wire logic       thermal_prewarn,
    input  wire logic       supply_undervolt,
    input  wire logic [5:0] short_circuit,
    input  wire logic [5:0] over_temp,
    input  wire logic [5:0] open_load,
    // Power stage controls
    output logic [5:0]      switch_drive,
    output logic            open_load_current_en,
    output logic            overcurrent_en,
    output logic            standby
);

    // ********************************************************************
    // Input synchronisation
    // ********************************************************************
    logic [hbsc_pkg::SY_W-1:0] raw_in;

    hbsc_sync_if #(.W(hbsc_pkg::SY_W)) sy ();

    assign raw_in[hbsc_pkg::SY_CS]           = cs_n;
    assign raw_in[hbsc_pkg::SY_CLK]          = sclk;
    assign raw_in[hbsc_pkg::SY_DIN]          = serial_in;
    assign raw_in[hbsc_pkg::SY_PWM]          = pwm_in;
    assign raw_in[hbsc_pkg::SY_TP]           = thermal_prewarn;
    assign raw_in[hbsc_pkg::SY_UV]           = supply_undervolt;
    assign raw_in[hbsc_pkg::SY_SC +: hbsc_pkg::NSW] = short_circuit;
    assign raw_in[hbsc_pkg::SY_OT +: hbsc_pkg::NSW] = over_temp;
    assign raw_in[hbsc_pkg::SY_OL +: hbsc_pkg::NSW] = open_load;

    hbsc_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (raw_in),
        .sy       (sy)
    );

    // ********************************************************************
    // Settled levels and edges
    // ********************************************************************
    logic       cs_fall;
    logic       cs_rise;
    logic       clk_fall;
    logic       clk_rise;
    logic       din;
    logic       pwm_lvl;
    logic       tp_lvl;
    logic       uv_lvl;
    logic [5:0] sc_lvl;
    logic [5:0] ot_lvl;
    logic [5:0] ol_lvl;

    assign cs_fall  = sy.fall[hbsc_pkg::SY_CS];
    assign cs_rise  = sy.rise[hbsc_pkg::SY_CS];
    assign clk_fall = sy.fall[hbsc_pkg::SY_CLK];
    assign clk_rise = sy.rise[hbsc_pkg::SY_CLK];
    assign din      = sy.level[hbsc_pkg::SY_DIN];
    assign pwm_lvl  = sy.level[hbsc_pkg::SY_PWM];
    assign tp_lvl   = sy.level[hbsc_pkg::SY_TP];
    assign uv_lvl   = sy.level[hbsc_pkg::SY_UV];
    assign sc_lvl   = sy.level[hbsc_pkg::SY_SC +: hbsc_pkg::NSW];
    assign ot_lvl   = sy.level[hbsc_pkg::SY_OT +: hbsc_pkg::NSW];
    assign ol_lvl   = sy.level[hbsc_pkg::SY_OL +: hbsc_pkg::NSW];

    // ********************************************************************
    // State
    // ********************************************************************
    hbsc_pkg::hbsc_state_t q;
    hbsc_pkg::hbsc_state_t d;

    // ********************************************************************
    // Command decode
    // ********************************************************************
    logic        run_mode;
    logic        ol_enable;
    logic        oc_enable;
    logic        frame_ok;
    logic        any_event;
    logic [5:0]  fault_evt;
    logic [5:0]  sw_eff;
    logic [5:0]  sw_stat;
    logic [5:0]  sw_drive;
    logic [15:0] status_word;

    assign run_mode  = q.cmd[hbsc_pkg::CMD_RUN];
    assign ol_enable = ~q.cmd[hbsc_pkg::CMD_OLD_N];
    assign oc_enable = q.cmd[hbsc_pkg::CMD_OCS];
    assign frame_ok  = q.active && (q.cnt == hbsc_pkg::FRAME_BITS);
    assign any_event = |fault_evt;

    // ********************************************************************
    // Per-switch logic
    // ********************************************************************
    for (genvar i = 0; i < hbsc_pkg::NSW; i++) begin : g_sw
        logic sw_cmd;
        logic pwm_sel;

        assign sw_cmd  = q.cmd[hbsc_pkg::CMD_SW_LSB + i];
        assign pwm_sel = q.cmd[hbsc_pkg::CMD_PWM_LSB + i];

        // Shutdown events latch per switch
        assign fault_evt[i] = ot_lvl[i] | (sc_lvl[i] & oc_enable);

        // Switch is on unless standby, undervoltage or tripped
        assign sw_eff[i] = sw_cmd & run_mode & ~uv_lvl & ~q.trip[i];

        // Open load reported only for switches that are off
        assign sw_stat[i] = (ol_enable & ~sw_eff[i]) ? ol_lvl[i] : sw_eff[i];

        // PWM gating masks the static enable
        assign sw_drive[i] = sw_eff[i] & (~pwm_sel | pwm_lvl);
    end

    // ********************************************************************
    // Status word
    // ********************************************************************
    assign status_word = {
        q.supply_fail_flag,
        ~run_mode,
        q.overload_flag,
        hbsc_pkg::ST_UNUSED,
        sw_stat,
        tp_lvl
    };

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        d = q;

        // Sticky flags, set takes precedence over any clear
        d.trip = q.trip | fault_evt;
        d.overload_flag  = q.overload_flag | any_event;
        d.supply_fail_flag  = q.supply_fail_flag | uv_lvl;

        if (cs_fall) begin
            // Open frame and present prewarning bit at once
            d.active = 1'b1;
            d.cnt    = hbsc_pkg::CNT_ZERO;
            d.shout  = status_word;
            d.dout   = status_word[hbsc_pkg::ST_TP];
            d.doe    = 1'b1;
        end else if (cs_rise) begin
            // Close frame, release data out
            d.active = 1'b0;
            d.doe    = 1'b0;
            d.dout   = 1'b0;
            if (frame_ok) begin
                d.cmd = q.shin;
                if (q.shin[hbsc_pkg::CMD_CLR]) begin
                    d.trip = fault_evt;
                    d.overload_flag  = any_event;
                    d.supply_fail_flag  = uv_lvl;
                end
            end
            // Short or long frames change nothing
        end else if (q.active) begin
            if (clk_fall) begin
                // Bit 0 enters first and ends at the bottom
                d.shin = {din, q.shin[hbsc_pkg::CMD_W-1:1]};
                if (q.cnt != hbsc_pkg::CNT_MAX) begin
                    d.cnt = q.cnt + hbsc_pkg::CNT_ONE;
                end
            end
            if (clk_rise && (q.cnt != hbsc_pkg::CNT_ZERO)) begin
                // Next status bit after each sampled input bit
                d.shout = q.shout >> 1;
                d.dout  = q.shout[1];
            end
        end

        // Registered power stage controls
        d.gate    = sw_drive;
        d.ol_en   = ol_enable;
        d.oc_en   = oc_enable;
        d.standby = ~run_mode;
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q         <= '0;
            q.cmd     <= hbsc_pkg::CMD_RESET;
            q.ol_en   <= 1'b0;
            q.oc_en   <= 1'b1;
            q.standby <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign serial_out           = q.dout;
    assign serial_out_oe        = q.doe;
    assign switch_drive         = q.gate;
    assign open_load_current_en = q.ol_en;
    assign overcurrent_en       = q.oc_en;
    assign standby              = q.standby;

endmodule : hbsc_port

// ===== dv/hbsc_monitor.sv
/* Checker for the serial control port.
   Assumes it is bound to hbsc_port and sees only its ports. */
`timescale 1ns/1ps
module hbsc_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Serial link
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       serial_in,
    input wire logic       serial_out,
    input wire logic       serial_out_oe,
    // Detectors and PWM
    input wire logic       pwm_in,
    input wire logic       thermal_prewarn,
    input wire logic       supply_undervolt,
    input wire logic [5:0] short_circuit,
    input wire logic [5:0] over_temp,
    input wire logic [5:0] open_load,
    // Power stage
    input wire logic [5:0] switch_drive,
    input wire logic       open_load_current_en,
    input wire logic       overcurrent_en,
    input wire logic       standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****
    // Cycles since the last serial clock rise
    // ****
    logic       sclk_q;
    logic [2:0] age_q;
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
        if (!rst_n) age_q <= 3'h7;
        else if (sclk && !sclk_q) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    sequence s_sel;
        !cs_n [*5];
    endsequence
    sequence s_desel;
        cs_n [*5];
    endsequence
    a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:5] serial_out_oe)
        else $error("output enable late after select");
    a_oe_held: assert property (s_sel |-> serial_out_oe)
        else $error("output enable dropped while selected");
    a_oe_idle: assert property (s_desel |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_dout_on_rise: assert property (($changed(serial_out) && serial_out_oe
        && $past(serial_out_oe)) |-> age_q <= 3'h5)
        else $error("data out changed away from clock rise");
    a_cmd_at_release: assert property (($changed(standby) || $changed(overcurrent_en)
        || $changed(open_load_current_en)) |-> cs_n && $past(cs_n, 3))
        else $error("command applied while selected");
    a_standby_off: assert property (standby && $past(standby) |-> switch_drive == 6'h00)
        else $error("switch on in standby");
    a_reset_vals: assert property ($rose(rst_n) |-> overcurrent_en && !standby
        && !open_load_current_en && switch_drive == 6'h00 && !serial_out_oe)
        else $error("wrong values after reset");
    a_trip_off: assert property ((over_temp != 6'h00) [*6]
        |-> (switch_drive & over_temp) == 6'h00)
        else $error("overheated switch still on");
    a_uv_off: assert property (supply_undervolt [*6] |-> switch_drive == 6'h00)
        else $error("switch on during undervoltage");
endmodule : hbsc_monitor

bind hbsc_port hbsc_monitor i_mon (.clk, .rst_n, .cs_n, .sclk, .serial_in, .serial_out,
    .serial_out_oe, .pwm_in, .thermal_prewarn, .supply_undervolt, .short_circuit,
    .over_temp, .open_load, .switch_drive, .open_load_current_en, .overcurrent_en, .standby);

// ===== dv/hbsc_master.sv
/* Behavioural serial bus master at the port's link side.
   Assumes a 50 MHz clk; runs one frame for each go request. */
`timescale 1ns/1ps
module hbsc_master (
    // Clock
    input wire logic        clk,
    // Frame request
    input wire logic        go,
    input wire logic [15:0] word,
    input wire logic [4:0]  nbits,
    output logic [15:0]     rx,
    output logic            done,
    // Link pins
    output logic            cs_n,
    output logic            sclk,
    output logic            serial_in,
    input wire logic        miso
);
    // Half period of the 160 ns link clock
    task automatic half;
        repeat (4) @(posedge clk);
        #1;
    endtask : half
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
        rx = 16'h0000;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (!go) begin
                done = 1'b0;
            end else if (!done) begin
                #1 cs_n = 1'b0;
                half();
                half();
                for (int i = 0; i < nbits; i++) begin
                    sclk = 1'b1;
                    serial_in = (i < 16) ? word[i[3:0]] : 1'b0;
                    half();
                    rx[i[3:0]] = miso;
                    sclk = 1'b0;
                    half();
                end
                if (nbits == 5'h00) rx[0] = miso;
                cs_n = 1'b1;
                serial_in = 1'b0;
                half();
                done = 1'b1;
            end
        end
    end
endmodule : hbsc_master

// ===== dv/testbench.sv
/* Self-checking bench for the serial control port.
   Assumes the link master model and the bound checker. */
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        go = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [4:0]  nbits = 5'h10;
    logic [15:0] rx;
    logic        done, cs_n, sclk, serial_in, serial_out, serial_out_oe;
    logic        pwm_in = 1'b0;
    logic        thermal_prewarn = 1'b0;
    logic        supply_undervolt = 1'b0;
    logic [5:0]  short_circuit = 6'h00;
    logic [5:0]  over_temp = 6'h00;
    logic [5:0]  open_load = 6'h09;
    logic [5:0]  switch_drive;
    logic        open_load_current_en, overcurrent_en, standby;
    wire         miso = serial_out_oe ? serial_out : 1'bz;
    wire  [15:0] outs = {standby, overcurrent_en, open_load_current_en,
                         serial_out_oe, 6'h00, switch_drive};
    int          n_mismatch = 0;
    int          compares = 0;
    always #10 clk = ~clk;
    hbsc_port i_dut (.clk, .rst_n, .cs_n, .sclk, .serial_in, .serial_out, .serial_out_oe,
        .pwm_in, .thermal_prewarn, .supply_undervolt, .short_circuit, .over_temp,
        .open_load, .switch_drive, .open_load_current_en, .overcurrent_en, .standby);
    hbsc_master i_master (.clk, .go, .word, .nbits, .rx, .done, .cs_n, .sclk,
        .serial_in, .miso);
    // ****
    // Shared tasks
    // ****
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic [15:0] w, input logic [4:0] n);
        int k;
        word = w;
        nbits = n;
        go = 1'b1;
        for (k = 0; k < 3000 && !done; k++) cyc(1);
        if (!done) begin
            n_mismatch++;
            $display("MISMATCH frame done expected 1 seen 0");
            summarize();
        end
        go = 1'b0;
        cyc(4);
    endtask : xfer
    // ****
    // Scenarios
    // ****
    task automatic t_switch;
        xfer(16'hE054, 5'h10);
        chk("status", 16'h0000, rx);
        chk("outputs", 16'h402A, outs);
        xfer(16'hE02A, 5'h10);
        chk("status", 16'h0054, rx);
        chk("outputs", 16'h4015, outs);
    endtask : t_switch
    task automatic t_abort;
        thermal_prewarn = 1'b1;
        cyc(4);
        xfer(16'h0000, 5'h00);
        chk("prewarn", 16'h0001, {15'h0000, rx[0]});
        chk("outputs", 16'h4015, outs);
        xfer(16'h6000, 5'h0F);
        xfer(16'h6000, 5'h11);
        chk("outputs", 16'h4015, outs);
    endtask : t_abort
    task automatic t_pwm;
        xfer(16'hE082, 5'h10);
        chk("status", 16'h002B, rx);
        thermal_prewarn = 1'b0;
        cyc(8);
        chk("outputs", 16'h4000, outs);
        pwm_in = 1'b1;
        cyc(8);
        chk("outputs", 16'h4001, outs);
        pwm_in = 1'b0;
        cyc(8);
    endtask : t_pwm
    task automatic t_standby;
        xfer(16'h0000, 5'h10);
        chk("status", 16'h0002, rx);
        chk("outputs", 16'hA000, outs);
        xfer(16'h0000, 5'h10);
        chk("status", 16'h4012, rx);
    endtask : t_standby
    task automatic t_flags;
        xfer(16'hA002, 5'h10);
        short_circuit = 6'h01;
        cyc(8);
        short_circuit = 6'h00;
        xfer(16'hE002, 5'h10);
        chk("status", 16'h0002, rx);
        over_temp = 6'h01;
        cyc(8);
        over_temp = 6'h00;
        supply_undervolt = 1'b1;
        cyc(8);
        supply_undervolt = 1'b0;
        cyc(4);
        chk("outputs", 16'h4000, outs);
        xfer(16'hE003, 5'h10);
        chk("status", 16'hA000, rx);
        chk("outputs", 16'h4001, outs);
        short_circuit = 6'h01;
        cyc(8);
        short_circuit = 6'h00;
        xfer(16'hE002, 5'h10);
        chk("status", 16'h2000, rx);
    endtask : t_flags
    initial begin
        cyc(8);
        rst_n = 1'b1;
        cyc(2);
        chk("outputs", 16'h4000, outs);
        t_switch();
        t_abort();
        t_pwm();
        t_standby();
        t_flags();
        summarize();
    end
endmodule : testbench
